// [tb/cmd_host.sv]
// Fieldbus host model that writes command words into the drive
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
    // Clock
    input wire logic i_clk_sys,
    // Command word write
    output logic o_wr,
    output logic [15:0] o_data
);
    initial begin
        o_wr = 1'b0;
        o_data = 16'h0000;
    end
    // One-cycle strobe; data is inverted after release so stale values never look valid
    task automatic put(input logic [15:0] d);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_data <= d;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_data <= ~d;
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the gear slave command and state logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gear_slave_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] mode = MODE_GEAR_SLAVE;
    logic [3:0] src = SRC_ENC1;
    logic signed [31:0] e1p = 32'h00001234, e1s = 32'h00000064, e2p = 32'h00005678;
    logic signed [31:0] e2s = 32'h00000020, bpos = 32'h00000000, slv = 32'h00000064;
    logic bvld = 1'b0, zero = 1'b0, pdone = 1'b0, cdone = 1'b0, cok = 1'b0, ferr = 1'b0;
    logic wr;
    logic [15:0] data, cmd_w, st_w;
    logic [1:0] ramp;
    logic [2:0] prof;
    logic signed [31:0] spd, mpos, p;
    logic prun, crun, dsync, pstart, cstart, en = 1'b1;
    logic [31:0] thr = 32'h00000002;
    logic [15:0] gtime = 16'h0003;
    int error_cnt = 0;
    int compares = 0;
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    cmd_host host (.i_clk_sys(clk), .o_wr(wr), .o_data(data));
    gear_slave_control_status dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(en),
        .i_cmd_wr(wr), .i_cmd_data(data), .i_op_mode(mode), .i_master_src(src),
        .i_gear_threshold(thr), .i_gear_time(gtime),
        .i_enc1_pos(e1p), .i_enc1_speed(e1s), .i_enc2_pos(e2p), .i_enc2_speed(e2s),
        .i_bus_pos(bpos), .i_bus_valid(bvld), .i_slave_speed(slv), .i_speed_zero(zero),
        .i_phase_done(pdone), .i_corr_done(cdone), .i_corr_ok(cok), .i_follow_err(ferr),
        .o_cmd_word(cmd_w), .o_state_word(st_w), .o_ramp_sel(ramp), .o_speed_target(spd),
        .o_master_pos(mpos), .o_direct_sync(dsync), .o_phase_run(prun), .o_phase_start(pstart),
        .o_phase_profile(prof), .o_corr_run(crun), .o_corr_start(cstart));
    // ********************************************************
    // Compare and timing helpers
    // ********************************************************
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_val(what, {31'h0, exp}, {31'h0, got});
    endtask
    // Let the edge's updates land before looking
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle pulse on a motion core done line
    task automatic pulse(input logic phase);
        @(posedge clk);
        if (phase) pdone <= 1'b1; else cdone <= 1'b1;
        cok <= 1'b1;
        @(posedge clk);
        pdone <= 1'b0;
        cdone <= 1'b0;
        tick(2);
    endtask
    task automatic end_of_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_gear;
        chk_val("state", 32'h0, {16'h0, st_w});
        chk_val("profile", 32'h1, {29'h0, prof});
        host.put(16'h0010);
        tick(3);
        chk_val("ramp", {30'h0, RAMP_ACCEL}, {30'h0, ramp});
        chk_val("target", 32'h64, spd);
        chk_val("cmd word", 32'h10, {16'h0, cmd_w});
        chk_bit("direct sync", 1'b1, dsync);
        tick(10);
        chk_bit("coupled", 1'b1, st_w[STS_TARGET_BIT]);
        // Speed error of 3 is outside the band, 2 sits on its edge
        @(posedge clk) slv <= 32'h00000067;
        tick(3);
        chk_bit("coupled", 1'b0, st_w[STS_TARGET_BIT]);
        @(posedge clk) begin
            slv <= 32'h00000066;
            gtime <= 16'h0005;
        end
        tick(6);
        chk_bit("coupled", 1'b0, st_w[STS_TARGET_BIT]);
        tick(2);
        chk_bit("coupled", 1'b1, st_w[STS_TARGET_BIT]);
    endtask
    task automatic t_halt;
        host.put(16'h0110);
        tick(3);
        chk_val("ramp", {30'h0, RAMP_BLOCK}, {30'h0, ramp});
        chk_bit("decel", 1'b0, st_w[STS_TARGET_BIT]);
        @(posedge clk) zero <= 1'b1;
        tick(2);
        chk_bit("stopped", 1'b1, st_w[STS_TARGET_BIT]);
        @(posedge clk) zero <= 1'b0;
        host.put(16'h0010);
        tick(10);
    endtask
    task automatic t_corr;
        host.put(16'h0030);
        tick(1);
        chk_bit("corr start", 1'b1, cstart);
        tick(2);
        chk_bit("corr start", 1'b0, cstart);
        chk_bit("corr run", 1'b1, crun);
        chk_bit("corr ok", 1'b0, st_w[STS_CORR_OK_BIT]);
        pulse(1'b0);
        chk_bit("corr ok", 1'b1, st_w[STS_CORR_OK_BIT]);
        chk_bit("done", 1'b1, st_w[STS_DONE_BIT]);
    endtask
    // Every profile code, with an abort between starts
    task automatic t_phase;
        for (int i = 0; i < 4; i++) begin
            host.put({2'h0, i[1:0], 12'h010});
            tick(3);
            chk_bit("phase run", 1'b0, prun);
            host.put({2'h0, i[1:0], 12'h210});
            tick(1);
            chk_bit("phase start", 1'b1, pstart);
            tick(2);
            chk_bit("phase start", 1'b0, pstart);
            chk_bit("phase run", 1'b1, prun);
            chk_val("profile", i + 1, {29'h0, prof});
            chk_bit("done", 1'b0, st_w[STS_DONE_BIT]);
            pulse(1'b1);
            chk_bit("done", 1'b1, st_w[STS_DONE_BIT]);
        end
    endtask
    // Bus sample from a master sending its internal actual position
    task automatic bus(input logic [31:0] v);
        @(posedge clk);
        bpos <= v;
        bvld <= 1'b1;
        @(posedge clk);
        bvld <= 1'b0;
        bpos <= ~v;
        repeat (15) @(posedge clk);
    endtask
    task automatic t_src;
        @(posedge clk) src <= SRC_ENC2;
        tick(4);
        chk_val("master pos", e2p, mpos);
        @(posedge clk) src <= SRC_OFF;
        tick(4);
        chk_val("master pos", 32'h0, mpos);
        @(posedge clk) src <= SRC_BUS;
        bus(32'h00000000);
        bus(32'h000000A0);
        tick(1);
        p = mpos;
        tick(1);
        chk_val("extrapolated", p + 32'h0000000A, mpos);
    endtask
    // A write while the enable is low must be lost
    task automatic t_stop;
        @(posedge clk) en <= 1'b0;
        host.put(16'h0040);
        tick(3);
        chk_val("frozen cmd", 32'h3210, {16'h0, cmd_w});
        @(posedge clk) en <= 1'b1;
        host.put(16'h0040);
        tick(3);
        chk_val("ramp", {30'h0, RAMP_DECEL}, {30'h0, ramp});
        chk_bit("direct sync", 1'b0, dsync);
        @(posedge clk) ferr <= 1'b1;
        tick(2);
        chk_bit("follow err", 1'b1, st_w[STS_FOLLOW_ERR_BIT]);
        @(posedge clk) mode <= 8'h00;
        tick(3);
        chk_val("ramp", {30'h0, RAMP_NONE}, {30'h0, ramp});
        chk_bit("follow err", 1'b0, st_w[STS_FOLLOW_ERR_BIT]);
    endtask
    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_gear();
        t_halt();
        t_corr();
        t_phase();
        t_src();
        t_stop();
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire

// [verilog/gear_slave_control_status.sv]
// Command and state word handling for the electronic gear slave mode
//
// Notes on behaviour
// - Gearing logic acts only while the operating mode code equals -3.
// - With gear start at 0 the axle is brought to standstill on the deceleration ramp.
// - With gear start at 1 gearing starts on the master speed with the acceleration ramp.
// - A rising command bit 5 starts position correction; at 0 nothing starts.
// - With stop-hold at 1 the axle stops on the block ramp and stays enabled.
// - Command bit 9 at 1 starts phasing; at 0 phasing is disabled or aborted.
// - The phasing profile used is the two-bit field in bits 13..12 plus one.
// - State bit 8 is 0 while phasing or correction runs or none started, 1 when done.
// - State bit 10 shows coupling with stop-hold 0, or standstill with stop-hold 1.
// - State bit 12 is 0 while correction runs or never started, 1 on success.
// - The source selector picks none, encoder 1, or encoder 2 as master.
// - Setting 11 takes the master position from the bus field and extrapolates it.
// - State bit 10 is set once slave speed meets the in-gear threshold and time.
`timescale 1ns/1ps
`default_nettype none
module gear_slave_control_status
    import gear_slave_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int TIME_W = 16,
    parameter int EXTRAP_SHIFT = 4
) (
    // Clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Command word access
    input wire logic i_cmd_wr,
    input wire logic [15:0] i_cmd_data,
    input wire logic [7:0] i_op_mode,
    // Configuration
    input wire logic [3:0] i_master_src,
    input wire logic [POS_W-1:0] i_gear_threshold,
    input wire logic [TIME_W-1:0] i_gear_time,
    // Master inputs
    input wire logic signed [POS_W-1:0] i_enc1_pos,
    input wire logic signed [POS_W-1:0] i_enc1_speed,
    input wire logic signed [POS_W-1:0] i_enc2_pos,
    input wire logic signed [POS_W-1:0] i_enc2_speed,
    input wire logic signed [POS_W-1:0] i_bus_pos,
    input wire logic i_bus_valid,
    // Motion core feedback
    input wire logic signed [POS_W-1:0] i_slave_speed,
    input wire logic i_speed_zero,
    input wire logic i_phase_done,
    input wire logic i_corr_done,
    input wire logic i_corr_ok,
    input wire logic i_follow_err,
    // Words
    output logic [15:0] o_cmd_word,
    output logic [15:0] o_state_word,
    // Motion core control
    output logic [1:0] o_ramp_sel,
    output logic signed [POS_W-1:0] o_speed_target,
    output logic signed [POS_W-1:0] o_master_pos,
    output logic o_direct_sync,
    output logic o_phase_run,
    output logic o_phase_start,
    output logic [2:0] o_phase_profile,
    output logic o_corr_run,
    output logic o_corr_start
);

    // ********************************************************
    // Master source and coupling
    // ********************************************************
    logic signed [POS_W-1:0] src_pos;
    logic signed [POS_W-1:0] src_speed;
    logic coupled;
    logic gear_arm;

    master_source_select #(
        .POS_W(POS_W),
        .EXTRAP_SHIFT(EXTRAP_SHIFT)
    ) u_source (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_src(i_master_src),
        .i_enc1_pos(i_enc1_pos),
        .i_enc1_speed(i_enc1_speed),
        .i_enc2_pos(i_enc2_pos),
        .i_enc2_speed(i_enc2_speed),
        .i_bus_pos(i_bus_pos),
        .i_bus_valid(i_bus_valid),
        .o_pos(src_pos),
        .o_speed(src_speed)
    );

    in_gear_detect #(
        .SPD_W(POS_W),
        .TIME_W(TIME_W)
    ) u_in_gear (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_arm(gear_arm),
        .i_master_speed(src_speed),
        .i_slave_speed(i_slave_speed),
        .i_threshold(i_gear_threshold),
        .i_hold_time(i_gear_time),
        .o_coupled(coupled)
    );

    // ********************************************************
    // Command decode
    // ********************************************************
    logic [15:0] cmd_reg;
    logic corr_prev_reg;
    logic phase_prev_reg;
    logic mode_active;
    logic gear_bit;
    logic corr_bit;
    logic halt_bit;
    logic phase_bit;
    logic [1:0] profile_field;
    logic corr_rise;
    logic phase_rise;

    assign mode_active = (i_op_mode == MODE_GEAR_SLAVE);
    assign gear_bit = cmd_reg[CMD_GEAR_START_BIT];
    assign corr_bit = cmd_reg[CMD_CORR_START_BIT];
    assign halt_bit = cmd_reg[CMD_HALT_BIT];
    assign phase_bit = cmd_reg[CMD_PHASE_START_BIT];
    assign profile_field = cmd_reg[CMD_PHASE_PROFILE_HI:CMD_PHASE_PROFILE_LO];
    // Starts are edges so a held bit does not retrigger after completion
    assign corr_rise = mode_active && corr_bit && !corr_prev_reg;
    assign phase_rise = mode_active && phase_bit && !phase_prev_reg;
    // Detector only armed while actually geared and not held
    assign gear_arm = mode_active && gear_bit && !halt_bit;

    // Command word storage and edge history
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cmd_reg <= CMD_RESET;
            corr_prev_reg <= 1'b0;
            phase_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (i_cmd_wr) begin
                cmd_reg <= i_cmd_data;
            end
            corr_prev_reg <= mode_active && corr_bit;
            phase_prev_reg <= mode_active && phase_bit;
        end
    end

    // ********************************************************
    // Gear state machine
    // ********************************************************
    gear_state_t state_reg;
    gear_state_t state_next;
    logic [1:0] ramp_next;
    logic signed [POS_W-1:0] target_next;

    always_comb begin
        state_next = state_reg;
        ramp_next = RAMP_NONE;
        target_next = '0;
        case (state_reg)
            ST_OFF: begin
                if (mode_active) begin
                    state_next = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                if (halt_bit) begin
                    state_next = ST_HALTED;
                end else if (gear_bit) begin
                    state_next = ST_GEARING;
                end
            end
            ST_GEARING: begin
                if (halt_bit) begin
                    state_next = ST_HALTED;
                end else if (!gear_bit) begin
                    state_next = ST_STOPPING;
                end
            end
            ST_HALTED: begin
                if (!halt_bit) begin
                    state_next = gear_bit ? ST_GEARING : ST_STOPPING;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (!mode_active) begin
            state_next = ST_OFF;
        end
        // Outputs follow the target state so the ramp answers one cycle after the command
        case (state_next)
            ST_STOPPING: begin
                ramp_next = RAMP_DECEL;
            end
            ST_GEARING: begin
                ramp_next = RAMP_ACCEL;
                target_next = src_speed;
            end
            ST_HALTED: begin
                ramp_next = RAMP_BLOCK;
            end
            default: begin
                ramp_next = RAMP_NONE;
            end
        endcase
    end

    // ********************************************************
    // State word flags
    // ********************************************************
    logic done_next;
    logic ok_next;
    logic target_bit_next;
    logic [15:0] state_word_next;

    // Set wins over clear when a completion meets a new start
    assign done_next = (mode_active && (i_phase_done || i_corr_done))
        || (o_state_word[STS_DONE_BIT] && !(phase_rise || corr_rise));
    assign ok_next = (mode_active && i_corr_done && i_corr_ok)
        || (o_state_word[STS_CORR_OK_BIT] && !corr_rise);
    assign target_bit_next = mode_active
        && (halt_bit ? i_speed_zero : (gear_bit && coupled));

    always_comb begin
        state_word_next = STS_RESET;
        state_word_next[STS_DONE_BIT] = done_next;
        state_word_next[STS_TARGET_BIT] = target_bit_next;
        state_word_next[STS_CORR_OK_BIT] = ok_next;
        state_word_next[STS_FOLLOW_ERR_BIT] = mode_active && i_follow_err;
    end

    // ********************************************************
    // Output registers
    // ********************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= ST_OFF;
            o_cmd_word <= CMD_RESET;
            o_state_word <= STS_RESET;
            o_ramp_sel <= RAMP_NONE;
            o_speed_target <= '0;
            o_master_pos <= '0;
            o_direct_sync <= 1'b0;
            o_phase_run <= 1'b0;
            o_phase_start <= 1'b0;
            o_phase_profile <= 3'h1;
            o_corr_run <= 1'b0;
            o_corr_start <= 1'b0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            o_cmd_word <= cmd_reg;
            o_state_word <= state_word_next;
            o_ramp_sel <= ramp_next;
            o_speed_target <= target_next;
            o_master_pos <= src_pos;
            // Bit value 0 means direct synchronisation enabled
            o_direct_sync <= mode_active && !cmd_reg[CMD_DIRECT_SYNC_BIT];
            o_phase_run <= mode_active && phase_bit;
            o_phase_start <= phase_rise;
            o_phase_profile <= {1'b0, profile_field} + 3'h1;
            o_corr_run <= mode_active && corr_bit;
            o_corr_start <= corr_rise;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_mode_gate;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        !mode_active |=> (o_ramp_sel == RAMP_NONE) && !o_phase_run && !o_corr_start;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("active outside mode");

    property p_stop_decel;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (state_reg != ST_OFF && mode_active && !gear_bit && !halt_bit)
            |=> (o_ramp_sel == RAMP_DECEL) && (o_speed_target == 0);
    endproperty
    a_stop_decel: assert property (p_stop_decel) else $error("no decel stop");

    property p_gear_accel;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (state_reg != ST_OFF && mode_active && gear_bit && !halt_bit)
            |=> (o_ramp_sel == RAMP_ACCEL) && (o_speed_target == $past(src_speed));
    endproperty
    a_gear_accel: assert property (p_gear_accel) else $error("gearing not started");

    property p_corr_cause;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        o_corr_start |-> $past(corr_bit) && !$past(corr_prev_reg);
    endproperty
    a_corr_cause: assert property (p_corr_cause) else $error("correction without bit");

    property p_halt_block;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (state_reg != ST_OFF && mode_active && halt_bit) |=> (o_ramp_sel == RAMP_BLOCK);
    endproperty
    a_halt_block: assert property (p_halt_block) else $error("halt ramp wrong");

    property p_phase_abort;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        !phase_bit |=> !o_phase_run && !o_phase_start;
    endproperty
    a_phase_abort: assert property (p_phase_abort) else $error("phasing not aborted");

    property p_profile;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        1'b1 |=> (o_phase_profile == {1'b0, $past(profile_field)} + 3'h1);
    endproperty
    a_profile: assert property (p_profile) else $error("profile not n plus one");

    sequence s_start_no_done;
        (phase_rise || corr_rise) && !i_phase_done && !i_corr_done;
    endsequence

    property p_done_clear;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        s_start_no_done |=> !o_state_word[STS_DONE_BIT];
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared");

    property p_done_set;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (mode_active && i_phase_done) |=> o_state_word[STS_DONE_BIT];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");

    sequence s_halted_zero;
        mode_active && halt_bit && i_speed_zero;
    endsequence

    property p_halt_target;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        s_halted_zero |=> o_state_word[STS_TARGET_BIT];
    endproperty
    a_halt_target: assert property (p_halt_target) else $error("standstill not shown");

    property p_corr_ok;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (mode_active && i_corr_done && i_corr_ok) |=> o_state_word[STS_CORR_OK_BIT];
    endproperty
    a_corr_ok: assert property (p_corr_ok) else $error("success not shown");

    property p_coupled_shown;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (gear_arm && coupled) |=> o_state_word[STS_TARGET_BIT];
    endproperty
    a_coupled_shown: assert property (p_coupled_shown) else $error("coupling not shown");

endmodule
`default_nettype wire

// [verilog/gear_slave_pkg.sv]
// Constants shared by the gear slave command and status logic
package gear_slave_pkg;

    // ********************************************************
    // Operating mode
    // ********************************************************
    localparam logic [7:0] MODE_GEAR_SLAVE = 8'hFD; // Mode code -3 as two's complement

    // ********************************************************
    // Command word field positions
    // ********************************************************
    localparam int CMD_GEAR_START_BIT = 4;
    localparam int CMD_CORR_START_BIT = 5;
    localparam int CMD_DIRECT_SYNC_BIT = 6;
    localparam int CMD_HALT_BIT = 8;
    localparam int CMD_PHASE_START_BIT = 9;
    localparam int CMD_PHASE_PROFILE_LO = 12;
    localparam int CMD_PHASE_PROFILE_HI = 13;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ********************************************************
    // State word field positions
    // ********************************************************
    localparam int STS_DONE_BIT = 8;
    localparam int STS_TARGET_BIT = 10;
    localparam int STS_CORR_OK_BIT = 12;
    localparam int STS_FOLLOW_ERR_BIT = 13;
    localparam logic [15:0] STS_RESET = 16'h0000;

    // ********************************************************
    // Master position source selector codes
    // ********************************************************
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_ENC1 = 4'h1;
    localparam logic [3:0] SRC_ENC2 = 4'h2;
    localparam logic [3:0] SRC_BUS = 4'hB;

    // ********************************************************
    // Ramp selection handed to the motion core
    // ********************************************************
    localparam logic [1:0] RAMP_NONE = 2'h0;
    localparam logic [1:0] RAMP_ACCEL = 2'h1;  // Profile acceleration object 0x6083
    localparam logic [1:0] RAMP_DECEL = 2'h2;  // Profile deceleration object 0x6084
    localparam logic [1:0] RAMP_BLOCK = 2'h3;  // Ramp of the current motion block

    // ********************************************************
    // Gear state machine
    // ********************************************************
    typedef enum logic [1:0] {
        ST_OFF,
        ST_STOPPING,
        ST_GEARING,
        ST_HALTED
    } gear_state_t;

endpackage

// [verilog/in_gear_detect.sv]
// Coupling detector: speed error inside a threshold for a hold time
`timescale 1ns/1ps
`default_nettype none
module in_gear_detect #(
    parameter int SPD_W = 32,
    parameter int TIME_W = 16
) (
    // Clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Control
    input wire logic i_arm,
    input wire logic signed [SPD_W-1:0] i_master_speed,
    input wire logic signed [SPD_W-1:0] i_slave_speed,
    input wire logic [SPD_W-1:0] i_threshold,
    input wire logic [TIME_W-1:0] i_hold_time,
    // Result
    output logic o_coupled
);

    logic signed [SPD_W-1:0] diff;
    logic [SPD_W-1:0] abs_diff;
    logic in_band;
    logic [TIME_W-1:0] count_reg;

    // Speed error magnitude against threshold
    assign diff = i_master_speed - i_slave_speed;
    assign abs_diff = diff[SPD_W-1] ? SPD_W'(-diff) : SPD_W'(diff);
    assign in_band = i_arm && (abs_diff <= i_threshold);

    // Any excursion restarts the hold time, so a passing crossing never couples
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            count_reg <= '0;
            o_coupled <= 1'b0;
        end else if (i_clk_en) begin
            if (!in_band) begin
                count_reg <= '0;
                o_coupled <= 1'b0;
            end else if (count_reg >= i_hold_time) begin
                o_coupled <= 1'b1;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    property p_couple_cause;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        $rose(o_coupled) |-> ($past(in_band) && ($past(count_reg) >= $past(i_hold_time)));
    endproperty
    a_couple_cause: assert property (p_couple_cause) else $error("coupled without hold");

endmodule
`default_nettype wire

// [verilog/master_source_select.sv]
// Master position source selection with extrapolation of bus samples
`timescale 1ns/1ps
`default_nettype none
module master_source_select
    import gear_slave_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int EXTRAP_SHIFT = 4
) (
    // Clock, reset and enable
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Selector
    input wire logic [3:0] i_src,
    // Encoder inputs
    input wire logic signed [POS_W-1:0] i_enc1_pos,
    input wire logic signed [POS_W-1:0] i_enc1_speed,
    input wire logic signed [POS_W-1:0] i_enc2_pos,
    input wire logic signed [POS_W-1:0] i_enc2_speed,
    // Bus long field
    input wire logic signed [POS_W-1:0] i_bus_pos,
    input wire logic i_bus_valid,
    // Selected master
    output logic signed [POS_W-1:0] o_pos,
    output logic signed [POS_W-1:0] o_speed
);

    // ********************************************************
    // Extrapolation
    // ********************************************************
    logic signed [POS_W-1:0] last_reg;
    logic signed [POS_W-1:0] step_reg;
    logic signed [POS_W-1:0] delta;
    logic signed [POS_W-1:0] step_next;

    // Per-cycle step is the sample delta over a nominal interval; slow senders keep it moving
    assign delta = i_bus_pos - last_reg;
    assign step_next = delta >>> EXTRAP_SHIFT;

    // Sample capture and per-cycle advance between samples
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            last_reg <= '0;
            step_reg <= '0;
            o_pos <= '0;
            o_speed <= '0;
        end else if (i_clk_en) begin
            if (i_bus_valid) begin
                last_reg <= i_bus_pos;
                step_reg <= step_next;
            end
            if (i_src == SRC_ENC1) begin
                o_pos <= i_enc1_pos;
                o_speed <= i_enc1_speed;
            end else if (i_src == SRC_ENC2) begin
                o_pos <= i_enc2_pos;
                o_speed <= i_enc2_speed;
            end else if (i_src == SRC_BUS) begin
                o_pos <= i_bus_valid ? i_bus_pos : o_pos + step_reg;
                o_speed <= i_bus_valid ? step_next : step_reg;
            end else begin
                o_pos <= '0;
                o_speed <= '0;
            end
        end
    end

    property p_enc1_follow;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (i_src == SRC_ENC1) |=> (o_pos == $past(i_enc1_pos));
    endproperty
    a_enc1_follow: assert property (p_enc1_follow) else $error("encoder 1 not followed");

    property p_bus_take;
        @(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
        (i_src == SRC_BUS && i_bus_valid) |=> (o_pos == $past(i_bus_pos));
    endproperty
    a_bus_take: assert property (p_bus_take) else $error("bus sample not taken");

endmodule
`default_nettype wire
